// ### inc/remote_i2c_pkg.sv
// Constants, register map and state types shared by the control-channel block.
package remote_i2c_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_INPUT_CRC = 8'h04;
	localparam logic [7:0] ADDR_BUS_OPT = 8'h05;
	localparam logic [7:0] ADDR_DES = 8'h06;
	localparam logic [7:0] ADDR_T0 = 8'h07;
	localparam logic [7:0] ADDR_ALIAS = 8'h08;
	localparam logic [7:0] ADDR_CRC_LO = 8'h0a;
	localparam logic [7:0] ADDR_CRC_HI = 8'h0b;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_INPUT_CRC = 8'h80;
	localparam logic [7:0] RST_BUS_OPT = 8'h00;
	localparam logic [6:0] RST_ADDR7 = 7'h00;
	localparam logic RST_FREEZE = 1'b0;

	// ==========================================================
	// Field positions
	localparam int BIT_FAILSAFE = 7;
	localparam int BIT_CRC_CLR = 5;
	localparam int BIT_SDA_DLY_LO = 3;
	localparam int BIT_WR_BLOCK = 2;
	localparam int BIT_WD_SPEED = 1;
	localparam int BIT_WD_DIS = 0;
	localparam int BIT_FREEZE = 0;
	localparam int ADDR_FIELD_LO = 1;

	// ==========================================================
	// Structure
	localparam int NUM_PORTS = 2;
	localparam int CRC_WIDTH = 16;
	localparam int BUS_CLEAR_PULSES = 9;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned CLK_HZ = 1000000000 / CLK_PERIOD_NS;
	localparam int unsigned SDA_BASE_NS = 240;
	localparam int unsigned SDA_STEP_NS = 40;
	localparam int unsigned SDA_BASE_CYC = SDA_BASE_NS / CLK_PERIOD_NS;
	localparam int unsigned SDA_STEP_CYC = SDA_STEP_NS / CLK_PERIOD_NS;
	localparam int unsigned WD_LONG_S = 1;
	localparam int unsigned WD_LONG_CYC = WD_LONG_S * CLK_HZ;
	localparam int unsigned WD_SHORT_US = 50;
	localparam int unsigned WD_SHORT_CYC = (WD_SHORT_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned SCL_HALF_NS = 5000;
	localparam int unsigned SCL_HALF_CYC = SCL_HALF_NS / CLK_PERIOD_NS;

	// ==========================================================
	// Watchdog states
	typedef enum logic [1:0] {
		WD_WATCH = 2'b00,
		WD_FREE = 2'b01,
		WD_CLEAR = 2'b10
	} wd_state_t;

endpackage

// ### inc/wdog_if.sv
// Carrier between the register bank and the bus watchdog.
`timescale 1ns/100ps
interface wdog_if;
	logic disable_wd;
	logic speedup;
	logic bus_free;
	logic clearing;
	logic scl_o;
	logic scl_oe;

	modport ctrl (
		output disable_wd,
		output speedup,
		input bus_free,
		input clearing,
		input scl_o,
		input scl_oe
	);

	modport timer (
		input disable_wd,
		input speedup,
		output bus_free,
		output clearing,
		output scl_o,
		output scl_oe
	);
endinterface

// ### logic/crc_err_counter.sv
// Saturating back channel CRC error counter with a level clear.
`timescale 1ns/100ps
module crc_err_counter
	import remote_i2c_pkg::*;
#(
	parameter int WIDTH = CRC_WIDTH
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clear,
	input wire logic err,
	output logic [WIDTH-1:0] count_q
);
	logic [WIDTH-1:0] count_d;

	// Clear is a level and wins over a counted error, so the count stays at zero while held.
	assign count_d = clear ? '0 :
		(err && (count_q != '1)) ? count_q + 1'b1 : count_q;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end
endmodule

// ### logic/i2c_bus_watchdog.sv
// I2C bus watchdog: idle timeout, bus-free flag and nine-pulse bus clear.
`timescale 1ns/100ps
module i2c_bus_watchdog
	import remote_i2c_pkg::*;
#(
	parameter int unsigned LONG_CYCLES = WD_LONG_CYC,
	parameter int unsigned SHORT_CYCLES = WD_SHORT_CYC,
	parameter int unsigned HALF_CYCLES = SCL_HALF_CYC
) (
	input wire logic mclk,
	input wire logic resetn,
	wdog_if.timer wd,
	input wire logic scl_in,
	input wire logic sda_in
);
	wd_state_t state_q;
	logic [31:0] cnt_q;
	logic [3:0] pulses_q;
	logic scl_prev_q;
	logic sda_prev_q;
	logic free_q;
	logic oe_q;
	wire activity;
	wire [31:0] limit;
	wire expired;
	wire half_done;

	assign activity = (scl_in ^ scl_prev_q) | (sda_in ^ sda_prev_q);
	assign limit = wd.speedup ? 32'(SHORT_CYCLES) : 32'(LONG_CYCLES);
	assign expired = (cnt_q >= limit - 32'h1);
	assign half_done = (cnt_q >= 32'(HALF_CYCLES) - 32'h1);

	assign wd.bus_free = free_q;
	assign wd.clearing = (state_q == WD_CLEAR);
	assign wd.scl_oe = oe_q;
	assign wd.scl_o = 1'b0;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_in;
			sda_prev_q <= sda_in;
		end
	end

	// The pulse train is open drain: SCL is pulled low for one half period, then released.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= WD_WATCH;
			cnt_q <= 32'h0;
			pulses_q <= 4'h0;
			free_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (wd.disable_wd) begin
			state_q <= WD_WATCH;
			cnt_q <= 32'h0;
			pulses_q <= 4'h0;
			free_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			case (state_q)
				WD_WATCH: begin
					if (activity) begin
						cnt_q <= 32'h0;
					end else if (expired) begin
						cnt_q <= 32'h0;
						if (sda_in) begin
							free_q <= 1'b1;
							state_q <= WD_FREE;
						end else begin
							oe_q <= 1'b1;
							pulses_q <= 4'h0;
							state_q <= WD_CLEAR;
						end
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				WD_FREE: begin
					if (activity) begin
						free_q <= 1'b0;
						cnt_q <= 32'h0;
						state_q <= WD_WATCH;
					end
				end
				WD_CLEAR: begin
					if (half_done) begin
						cnt_q <= 32'h0;
						if (oe_q) begin
							oe_q <= 1'b0;
							pulses_q <= pulses_q + 4'h1;
						end else if (pulses_q == 4'(BUS_CLEAR_PULSES)) begin
							state_q <= WD_WATCH;
						end else begin
							oe_q <= 1'b1;
						end
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				default: begin
					state_q <= WD_WATCH;
					cnt_q <= 32'h0;
					oe_q <= 1'b0;
				end
			endcase
		end
	end
endmodule

// ### logic/remote_i2c_channel_control.sv
// Register bank and address handling for the serializer's control channel.
`timescale 1ns/100ps

module remote_i2c_channel_control
	import remote_i2c_pkg::*;
#(
	parameter int unsigned WD_LONG_CYCLES = WD_LONG_CYC,
	parameter int unsigned WD_SHORT_CYCLES = WD_SHORT_CYC,
	parameter int unsigned SCL_HALF_CYCLES = SCL_HALF_CYC
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_from_remote,
	output logic [7:0] reg_rdata_q,
	output logic reg_rvalid_q,
	output logic reg_wr_refused_q,
	input wire logic second_port_select,
	input wire logic [NUM_PORTS-1:0] rx_lock,
	input wire logic [NUM_PORTS-1:0][6:0] rx_des_addr,
	input wire logic [NUM_PORTS-1:0] crc_err,
	input wire logic txn_valid,
	input wire logic txn_port,
	input wire logic [6:0] txn_addr,
	output logic fwd_valid_q,
	output logic [6:0] fwd_addr_q,
	output logic fwd_remapped_q,
	output logic fwd_miss_q,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe,
	output logic bus_free_q,
	output logic bus_clearing_q,
	output logic failsafe_low_q,
	output logic [5:0] sda_delay_cycles_q
);

	// ==========================================================
	// Helpers

	// An address field of zero never matches; that is how a zero disables a path.
	function automatic logic addr_hit(input logic [6:0] addr, input logic [6:0] field);
		addr_hit = (field != 7'h00) && (addr == field);
	endfunction

	// ==========================================================
	// Register storage
	logic [7:0] input_crc_q;
	logic [7:0] bus_opt_q;
	logic [NUM_PORTS-1:0][6:0] des_addr_q;
	logic [NUM_PORTS-1:0] freeze_q;
	logic [NUM_PORTS-1:0][6:0] t0_addr_q;
	logic [NUM_PORTS-1:0][6:0] alias_q;
	logic [NUM_PORTS-1:0] lock_prev_q;
	logic [NUM_PORTS-1:0][CRC_WIDTH-1:0] crc_count;

	// ==========================================================
	// Write decode
	wire wr_block;
	wire wr_ok;
	wire wr_refused;
	wire wr_input_crc;
	wire wr_bus_opt;
	wire wr_des;
	wire wr_t0;
	wire wr_alias;
	wire crc_clear;

	assign wr_block = bus_opt_q[BIT_WR_BLOCK];
	// Only register writes are gated; the forwarding path below ignores this bit.
	assign wr_refused = reg_wr && reg_from_remote && wr_block;
	assign wr_ok = reg_wr && !wr_refused;
	assign wr_input_crc = wr_ok && (reg_addr == ADDR_INPUT_CRC);
	assign wr_bus_opt = wr_ok && (reg_addr == ADDR_BUS_OPT);
	assign wr_des = wr_ok && (reg_addr == ADDR_DES);
	assign wr_t0 = wr_ok && (reg_addr == ADDR_T0);
	assign wr_alias = wr_ok && (reg_addr == ADDR_ALIAS);
	assign crc_clear = input_crc_q[BIT_CRC_CLR];

	// ==========================================================
	// Shared registers

	// Reserved positions are masked on write, so they always hold zero.
	localparam logic [7:0] INPUT_CRC_MASK = 8'ha0;
	localparam logic [7:0] BUS_OPT_MASK = 8'h1f;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			input_crc_q <= RST_INPUT_CRC;
		end else if (wr_input_crc) begin
			input_crc_q <= reg_wdata & INPUT_CRC_MASK;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bus_opt_q <= RST_BUS_OPT;
		end else if (wr_bus_opt) begin
			bus_opt_q <= reg_wdata & BUS_OPT_MASK;
		end
	end

	// ==========================================================
	// Per-port registers
	wire psel;

	assign psel = second_port_select;

	generate
		for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
			wire port_hit;
			wire lock_rise;

			assign port_hit = (psel == 1'(p));
			assign lock_rise = rx_lock[p] && !lock_prev_q[p];

			// A software write in the same cycle as a lock edge wins over the auto-load.
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					des_addr_q[p] <= RST_ADDR7;
					freeze_q[p] <= RST_FREEZE;
				end else if (wr_des && port_hit) begin
					des_addr_q[p] <= reg_wdata[7:ADDR_FIELD_LO];
					freeze_q[p] <= reg_wdata[BIT_FREEZE];
				end else if (lock_rise && !freeze_q[p]) begin
					des_addr_q[p] <= rx_des_addr[p];
				end
			end

			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					t0_addr_q[p] <= RST_ADDR7;
				end else if (wr_t0 && port_hit) begin
					t0_addr_q[p] <= reg_wdata[7:ADDR_FIELD_LO];
				end
			end

			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					alias_q[p] <= RST_ADDR7;
				end else if (wr_alias && port_hit) begin
					alias_q[p] <= reg_wdata[7:ADDR_FIELD_LO];
				end
			end

			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					lock_prev_q[p] <= 1'b0;
				end else begin
					lock_prev_q[p] <= rx_lock[p];
				end
			end

			// The clear bit is common to both ports' counters.
			crc_err_counter #(
				.WIDTH(CRC_WIDTH)
			) u_crc (
				.mclk(mclk),
				.resetn(resetn),
				.clear(crc_clear),
				.err(crc_err[p]),
				.count_q(crc_count[p])
			);
		end
	endgenerate

	// ==========================================================
	// Read path
	logic [7:0] rd_mux;
	wire [CRC_WIDTH-1:0] crc_sel;

	assign crc_sel = crc_count[psel];

	always_comb begin
		case (reg_addr)
			ADDR_INPUT_CRC: rd_mux = input_crc_q;
			ADDR_BUS_OPT: rd_mux = bus_opt_q;
			ADDR_DES: rd_mux = {des_addr_q[psel], freeze_q[psel]};
			ADDR_T0: rd_mux = {t0_addr_q[psel], 1'b0};
			ADDR_ALIAS: rd_mux = {alias_q[psel], 1'b0};
			ADDR_CRC_LO: rd_mux = crc_sel[7:0];
			ADDR_CRC_HI: rd_mux = crc_sel[15:8];
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_q <= 8'h00;
			reg_rvalid_q <= 1'b0;
			reg_wr_refused_q <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_rd;
			reg_wr_refused_q <= wr_refused;
			if (reg_rd) begin
				reg_rdata_q <= rd_mux;
			end
		end
	end

	// ==========================================================
	// Transaction forwarding
	wire [6:0] txn_des;
	wire [6:0] txn_t0;
	wire [6:0] txn_alias;
	wire des_hit;
	wire t0_hit;

	assign txn_des = des_addr_q[txn_port];
	assign txn_t0 = t0_addr_q[txn_port];
	assign txn_alias = alias_q[txn_port];
	assign des_hit = addr_hit(txn_addr, txn_des);
	// The alias only opens a path when the remapped address is also non-zero.
	assign t0_hit = !des_hit && addr_hit(txn_addr, txn_alias) && (txn_t0 != 7'h00);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			fwd_valid_q <= 1'b0;
			fwd_addr_q <= 7'h00;
			fwd_remapped_q <= 1'b0;
			fwd_miss_q <= 1'b0;
		end else begin
			fwd_valid_q <= txn_valid && (des_hit || t0_hit);
			fwd_remapped_q <= txn_valid && t0_hit;
			fwd_miss_q <= txn_valid && !(des_hit || t0_hit);
			if (txn_valid) begin
				fwd_addr_q <= t0_hit ? txn_t0 : txn_addr;
			end
		end
	end

	// ==========================================================
	// Bus watchdog
	wdog_if wd ();

	assign wd.disable_wd = bus_opt_q[BIT_WD_DIS];
	assign wd.speedup = bus_opt_q[BIT_WD_SPEED];

	i2c_bus_watchdog #(
		.LONG_CYCLES(WD_LONG_CYCLES),
		.SHORT_CYCLES(WD_SHORT_CYCLES),
		.HALF_CYCLES(SCL_HALF_CYCLES)
	) u_wdog (
		.mclk(mclk),
		.resetn(resetn),
		.wd(wd.timer),
		.scl_in(scl_in),
		.sda_in(sda_in)
	);

	// SCL enable and bus-free are timer flops and pass straight through; scl_o is a constant low and clearing is registered below.
	assign scl_out = wd.scl_o;
	assign scl_oe = wd.scl_oe;
	assign bus_free_q = wd.bus_free;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bus_clearing_q <= 1'b0;
		end else begin
			bus_clearing_q <= wd.clearing;
		end
	end

	// ==========================================================
	// Static outputs
	wire [1:0] sda_sel;

	assign sda_sel = bus_opt_q[BIT_SDA_DLY_LO +: 2];

	// Delay is given in mclk cycles: 30 cycles for 240 ns plus 5 per step.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			failsafe_low_q <= RST_INPUT_CRC[BIT_FAILSAFE];
			sda_delay_cycles_q <= 6'(SDA_BASE_CYC);
		end else begin
			failsafe_low_q <= input_crc_q[BIT_FAILSAFE];
			sda_delay_cycles_q <= 6'(SDA_BASE_CYC + SDA_STEP_CYC * 32'(sda_sel));
		end
	end

endmodule

// ### tb/i2c_bus_model.sv
// Pulled-up I2C wires shared by the local host and the block.
`timescale 1ns/100ps
module i2c_bus_model (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic scl_oe,
	input wire logic sda_low,
	output logic scl_in,
	output logic sda_in,
	output int pulses
);
	logic scl_q;
	// Released open-drain wires float high through the pull-ups.
	assign scl_in = !scl_oe;
	assign sda_in = !sda_low;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			scl_q <= 1'b1;
			pulses <= 0;
		end else begin
			scl_q <= scl_in;
			if (scl_in && !scl_q)
				pulses <= pulses + 1;
		end
	end
endmodule

// ### tb/remote_i2c_channel_control_props.sv
// Port-level checks for the control-channel register bank.
`timescale 1ns/100ps
module remote_i2c_props
	import remote_i2c_pkg::*;
#(
	parameter int unsigned SCL_HALF_CYCLES = SCL_HALF_CYC
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_from_remote,
	input wire logic [7:0] reg_rdata_q,
	input wire logic reg_rvalid_q,
	input wire logic reg_wr_refused_q,
	input wire logic txn_valid,
	input wire logic fwd_valid_q,
	input wire logic fwd_remapped_q,
	input wire logic fwd_miss_q,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic bus_free_q,
	input wire logic failsafe_low_q,
	input wire logic [5:0] sda_delay_cycles_q
);
	// ==========
	// Shadow of the writable options
	logic [4:0] opt_q;
	logic fs_q;
	int unsigned hi_q;
	wire logic ok_wr = reg_wr && !(reg_from_remote && opt_q[2]);
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			opt_q <= 5'h00;
			fs_q <= 1'b1;
			hi_q <= 0;
		end else begin
			if (ok_wr && reg_addr == ADDR_BUS_OPT)
				opt_q <= reg_wdata[4:0];
			if (ok_wr && reg_addr == ADDR_INPUT_CRC)
				fs_q <= reg_wdata[7];
			hi_q <= scl_oe ? hi_q + 1 : 0;
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	// ==========
	// Properties
	property p_failsafe; fs_q == $past(fs_q) |-> failsafe_low_q == fs_q; endproperty
	a_failsafe: assert property (p_failsafe)
		else $error("failsafe level wrong");
	property p_delay; opt_q == $past(opt_q) |->
		sda_delay_cycles_q == 6'(SDA_BASE_CYC + SDA_STEP_CYC * opt_q[4:3]); endproperty
	a_delay: assert property (p_delay)
		else $error("sda delay wrong");
	property p_refuse; reg_wr && reg_from_remote && opt_q[2] |=> reg_wr_refused_q; endproperty
	a_refuse: assert property (p_refuse)
		else $error("remote write not refused");
	property p_accept; ok_wr |=> !reg_wr_refused_q; endproperty
	a_accept: assert property (p_accept)
		else $error("write wrongly refused");
	property p_rvalid; reg_rd |=> reg_rvalid_q; endproperty
	a_rvalid: assert property (p_rvalid)
		else $error("read not answered");
	property p_unmapped; reg_rd && reg_addr == 8'h09 |=> reg_rdata_q == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_fwd; txn_valid |=> fwd_valid_q != fwd_miss_q; endproperty
	a_fwd: assert property (p_fwd)
		else $error("transaction not classified");
	property p_remap; fwd_remapped_q |-> fwd_valid_q; endproperty
	a_remap: assert property (p_remap)
		else $error("remap without forward");
	property p_half; hi_q <= SCL_HALF_CYCLES; endproperty
	a_half: assert property (p_half)
		else $error("scl low too long");
	property p_dis; opt_q[0] && $past(opt_q[0]) |-> !scl_oe && !bus_free_q; endproperty
	a_dis: assert property (p_dis)
		else $error("watchdog active while disabled");
	property p_od; scl_out == 1'b0; endproperty
	a_od: assert property (p_od)
		else $error("scl driven high");
	c_refuse: cover property (reg_wr_refused_q);
	c_remap: cover property (fwd_remapped_q);
	c_clear: cover property ($rose(scl_oe));
	c_free: cover property ($rose(bus_free_q));
endmodule

bind remote_i2c_channel_control remote_i2c_props #(.SCL_HALF_CYCLES(SCL_HALF_CYCLES)) u_props (
	.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_from_remote(reg_from_remote),
	.reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
	.reg_wr_refused_q(reg_wr_refused_q), .txn_valid(txn_valid), .fwd_valid_q(fwd_valid_q),
	.fwd_remapped_q(fwd_remapped_q), .fwd_miss_q(fwd_miss_q), .scl_out(scl_out),
	.scl_oe(scl_oe), .bus_free_q(bus_free_q), .failsafe_low_q(failsafe_low_q),
	.sda_delay_cycles_q(sda_delay_cycles_q));

// ### tb/test_remote_i2c_channel_control.sv
// Self-checking bench for the control-channel register bank.
`timescale 1ns/100ps
module test_remote_i2c_channel_control;
	import remote_i2c_pkg::*;
	logic mclk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, reg_from_remote = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q;
	logic reg_rvalid_q, reg_wr_refused_q, second_port_select = 0, txn_valid = 0, txn_port = 0;
	logic [1:0] rx_lock = 2'h0, crc_err = 2'h0;
	logic [1:0][6:0] rx_des_addr = '0;
	logic [6:0] txn_addr = 7'h00, fwd_addr_q;
	logic fwd_valid_q, fwd_remapped_q, fwd_miss_q, scl_in, sda_in, scl_out, scl_oe;
	logic bus_free_q, bus_clearing_q, failsafe_low_q, host_sda_low = 0;
	logic [5:0] sda_delay_cycles_q;
	int errors = 0, n_compared = 0, pulses;

	initial begin
		forever #4 mclk = !mclk;
	end

	remote_i2c_channel_control #(.WD_LONG_CYCLES(20), .WD_SHORT_CYCLES(8),
		.SCL_HALF_CYCLES(2)) remote_i2c_channel_control_inst (
		.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_from_remote(reg_from_remote),
		.reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
		.reg_wr_refused_q(reg_wr_refused_q), .second_port_select(second_port_select),
		.rx_lock(rx_lock), .rx_des_addr(rx_des_addr), .crc_err(crc_err),
		.txn_valid(txn_valid), .txn_port(txn_port), .txn_addr(txn_addr),
		.fwd_valid_q(fwd_valid_q), .fwd_addr_q(fwd_addr_q), .fwd_remapped_q(fwd_remapped_q),
		.fwd_miss_q(fwd_miss_q), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out),
		.scl_oe(scl_oe), .bus_free_q(bus_free_q), .bus_clearing_q(bus_clearing_q),
		.failsafe_low_q(failsafe_low_q), .sda_delay_cycles_q(sda_delay_cycles_q));

	i2c_bus_model i2c_bus_model_inst (.mclk(mclk), .resetn(resetn), .scl_oe(scl_oe),
		.sda_low(host_sda_low), .scl_in(scl_in), .sda_in(sda_in), .pulses(pulses));

	// ==========
	// Shared helpers
	task automatic wrap_up;
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rem);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_from_remote = rem;
		reg_wr = 1;
		@(negedge mclk);
		reg_wr = 0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1;
		@(negedge mclk);
		reg_rd = 0;
		chk({7'h00, reg_rvalid_q}, 8'h01, "read valid");
		chk(reg_rdata_q, exp, what);
	endtask
	task automatic txn(input logic p, input logic [6:0] a, input logic [2:0] f,
		input logic [6:0] e);
		@(negedge mclk);
		txn_port = p;
		txn_addr = a;
		txn_valid = 1;
		@(negedge mclk);
		txn_valid = 0;
		chk({5'h0, fwd_valid_q, fwd_remapped_q, fwd_miss_q}, {5'h0, f}, "txn flags");
		if (f[2])
			chk({1'b0, fwd_addr_q}, {1'b0, e}, "txn address");
	endtask
	task automatic crcp(input logic [1:0] ports, input int n);
		repeat (n) begin
			@(negedge mclk);
			crc_err = ports;
			@(negedge mclk);
			crc_err = 2'h0;
		end
	endtask
	task automatic toggle;
		@(negedge mclk);
		host_sda_low = 1;
		@(negedge mclk);
		host_sda_low = 0;
	endtask

	// ==========
	// Scenarios
	task automatic t_reset;
		rdc(ADDR_INPUT_CRC, 8'h80, "reg04 reset");
		rdc(ADDR_BUS_OPT, 8'h00, "reg05 reset");
		rdc(ADDR_DES, 8'h00, "reg06 reset");
		rdc(ADDR_T0, 8'h00, "reg07 reset");
		rdc(ADDR_ALIAS, 8'h00, "reg08 reset");
		rdc(8'h09, 8'h00, "unmapped");
		chk({7'h0, failsafe_low_q}, 8'h01, "failsafe reset");
		chk({2'h0, sda_delay_cycles_q}, 8'(SDA_BASE_CYC), "delay reset");
	endtask
	task automatic t_regs;
		wr(ADDR_INPUT_CRC, 8'hff, 0);
		rdc(ADDR_INPUT_CRC, 8'ha0, "reg04 mask");
		wr(ADDR_INPUT_CRC, 8'h00, 0);
		idle(2);
		chk({7'h0, failsafe_low_q}, 8'h00, "failsafe high");
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_BUS_OPT, 8'(k << 3) | 8'he0, 0);
			idle(2);
			chk({2'h0, sda_delay_cycles_q}, 8'(SDA_BASE_CYC + SDA_STEP_CYC * k), "delay");
			rdc(ADDR_BUS_OPT, 8'(k << 3), "reg05 mask");
		end
		wr(ADDR_INPUT_CRC, 8'h80, 0);
		wr(ADDR_BUS_OPT, 8'h00, 0);
	endtask
	task automatic t_addr;
		rx_des_addr[0] = 7'h11;
		rx_lock[0] = 1;
		idle(3);
		rdc(ADDR_DES, 8'h22, "auto-load");
		txn(0, 7'h11, 3'b100, 7'h11);
		second_port_select = 1;
		rdc(ADDR_DES, 8'h00, "port1 view");
		wr(ADDR_DES, 8'h01, 0);
		rx_des_addr[1] = 7'h33;
		rx_lock[1] = 1;
		idle(3);
		rdc(ADDR_DES, 8'h01, "frozen");
		txn(1, 7'h00, 3'b001, 7'h00);
		second_port_select = 0;
		wr(ADDR_DES, 8'h44, 0);
		rdc(ADDR_DES, 8'h44, "overwrite");
		txn(0, 7'h22, 3'b100, 7'h22);
	endtask
	task automatic t_alias;
		wr(ADDR_ALIAS, 8'h40, 0);
		wr(ADDR_T0, 8'ha1, 0);
		rdc(ADDR_T0, 8'ha0, "reg07 bit0");
		txn(0, 7'h20, 3'b110, 7'h50);
		txn(0, 7'h21, 3'b001, 7'h00);
		wr(ADDR_T0, 8'h00, 0);
		txn(0, 7'h20, 3'b001, 7'h00);
		wr(ADDR_T0, 8'ha0, 0);
	endtask
	task automatic t_block;
		wr(ADDR_BUS_OPT, 8'h04, 0);
		wr(ADDR_ALIAS, 8'h60, 1);
		chk({7'h0, reg_wr_refused_q}, 8'h01, "refused");
		rdc(ADDR_ALIAS, 8'h40, "kept");
		txn(0, 7'h20, 3'b110, 7'h50);
		wr(ADDR_BUS_OPT, 8'h00, 0);
		wr(ADDR_ALIAS, 8'h60, 1);
		chk({7'h0, reg_wr_refused_q}, 8'h00, "accepted");
		rdc(ADDR_ALIAS, 8'h60, "stored");
	endtask
	task automatic t_crc;
		crcp(2'b11, 1);
		crcp(2'b01, 2);
		rdc(ADDR_CRC_LO, 8'h03, "crc port0");
		second_port_select = 1;
		rdc(ADDR_CRC_LO, 8'h01, "crc port1");
		second_port_select = 0;
		wr(ADDR_INPUT_CRC, 8'ha0, 0);
		crcp(2'b01, 1);
		rdc(ADDR_CRC_LO, 8'h00, "held clear");
		wr(ADDR_INPUT_CRC, 8'h80, 0);
		crcp(2'b01, 257);
		rdc(ADDR_CRC_LO, 8'h01, "crc low");
		rdc(ADDR_CRC_HI, 8'h01, "crc high");
	endtask
	task automatic t_wdog;
		int p;
		toggle();
		idle(15);
		chk({7'h0, bus_free_q}, 8'h00, "free early");
		idle(10);
		chk({7'h0, bus_free_q}, 8'h01, "free");
		wr(ADDR_BUS_OPT, 8'h02, 0);
		toggle();
		idle(4);
		chk({7'h0, bus_free_q}, 8'h00, "fast early");
		idle(6);
		chk({7'h0, bus_free_q}, 8'h01, "fast free");
		p = pulses;
		host_sda_low = 1;
		idle(20);
		chk({7'h0, bus_clearing_q}, 8'h01, "clearing");
		idle(30);
		chk(8'(pulses - p), 8'(BUS_CLEAR_PULSES), "clear pulses");
		host_sda_low = 0;
		wr(ADDR_BUS_OPT, 8'h03, 0);
		p = pulses;
		host_sda_low = 1;
		idle(40);
		chk(8'(pulses - p), 8'h00, "disabled clear");
		chk({7'h0, bus_clearing_q}, 8'h00, "disabled clearing");
		host_sda_low = 0;
		idle(30);
		chk({7'h0, bus_free_q}, 8'h00, "disabled free");
		wr(ADDR_BUS_OPT, 8'h00, 0);
	endtask

	initial begin
		repeat (3) @(negedge mclk);
		resetn = 1;
		t_reset();
		t_regs();
		t_addr();
		t_alias();
		t_block();
		t_crc();
		t_wdog();
		wrap_up();
	end
	initial begin
		#200000;
		errors++;
		wrap_up();
	end
endmodule
